//--- dcr_pkg.sv
// Purpose: constants and types for the dac control register bank
// Assumes: core clock is the device master clock
// Notes:   one 16-bit control word per latch, address over data
package dcr_pkg;

	// ------------------------------------------------------------
	// word layout
	// ------------------------------------------------------------
	localparam int WORD_W   = 16;
	localparam int ADDR_W   = 7;
	localparam int DATA_W   = 9;
	localparam int ATT_W    = 8;
	localparam int N_CH     = 8;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 9;
	localparam int DATA_MSB = 8;
	localparam int CNT_W    = 5;
	localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;

	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_LEFT1  = 7'h00;
	localparam logic [ADDR_W-1:0] ADDR_RIGHT1 = 7'h01;
	localparam logic [ADDR_W-1:0] ADDR_MZD    = 7'h02;
	localparam logic [ADDR_W-1:0] ADDR_PFC    = 7'h03;
	localparam logic [ADDR_W-1:0] ADDR_LEFT2  = 7'h04;
	localparam logic [ADDR_W-1:0] ADDR_RIGHT2 = 7'h05;
	localparam logic [ADDR_W-1:0] ADDR_LEFT3  = 7'h06;
	localparam logic [ADDR_W-1:0] ADDR_RIGHT3 = 7'h07;
	localparam logic [ADDR_W-1:0] ADDR_MASTER = 7'h08;
	localparam logic [ADDR_W-1:0] ADDR_DMZ    = 7'h09;
	localparam logic [ADDR_W-1:0] ADDR_RMP    = 7'h0a;
	localparam logic [ADDR_W-1:0] ADDR_MPDL   = 7'h0c;
	localparam logic [ADDR_W-1:0] ADDR_LEFT4  = 7'h0d;
	localparam logic [ADDR_W-1:0] ADDR_RIGHT4 = 7'h0e;
	localparam logic [ADDR_W-1:0] ADDR_CH4    = 7'h0f;
	localparam logic [ADDR_W-1:0] ADDR_SRST   = 7'h1f;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int UPDATE_BIT     = 8;
	localparam int DECODE_OFF_LEGACY_BIT = 6;
	localparam int DECODE_OFF_CH4_BIT    = 5;
	localparam logic [ATT_W-1:0]  ATT_MUTE  = 8'h00;
	localparam logic [ATT_W-1:0]  ATT_0DB   = 8'hff;
	localparam logic [DATA_W-1:0] RST_ATT   = 9'h0ff;
	localparam logic [DATA_W-1:0] RST_MZD   = 9'h120;
	localparam logic [DATA_W-1:0] RST_RMP   = 9'h080;
	localparam logic [DATA_W-1:0] RST_ZERO  = 9'h000;

	// ------------------------------------------------------------
	// timing: soft reset length in master clock periods
	// ------------------------------------------------------------
	localparam int SRST_MCLK_PERIODS = 2;
	localparam int CORE_PER_MCLK     = 1;
	localparam int SRST_CYCLES = SRST_MCLK_PERIODS * CORE_PER_MCLK;
	localparam int SRST_CNT_W  = $clog2(SRST_CYCLES + 1);

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0] mute_zero_detect_control;
		logic [DATA_W-1:0] phase_format_control;
		logic [DATA_W-1:0] master_attenuation;
		logic [DATA_W-1:0] deemph_mute_zero_control;
		logic [DATA_W-1:0] rate_mode_powerdown;
		logic [DATA_W-1:0] mute_pin_decode_legacy;
		logic [DATA_W-1:0] channel4_control;
	} dcr_ctrl_t;

	localparam dcr_ctrl_t CTRL_RST = '{
		mute_zero_detect_control: RST_MZD,
		phase_format_control:     RST_ZERO,
		master_attenuation:       RST_ATT,
		deemph_mute_zero_control: RST_ZERO,
		rate_mode_powerdown:      RST_RMP,
		mute_pin_decode_legacy:   RST_ZERO,
		channel4_control:         RST_ZERO
	};

	typedef struct packed {
		logic [1:0] clk_sync;
		logic [1:0] dat_sync;
		logic [1:0] lat_sync;
		logic [1:0] lost_sync;
		logic       clk_prev;
		logic       lat_prev;
		logic [WORD_W-1:0] shift;
		logic [CNT_W-1:0]  nbits;
		dcr_ctrl_t         ctrl;
		logic [N_CH-1:0][ATT_W-1:0] pending;
		logic [N_CH-1:0][ATT_W-1:0] active;
		logic              srst;
		logic [SRST_CNT_W-1:0] srst_cnt;
	} dcr_state_t;

endpackage

//--- dcr_bank.sv
// Purpose: control register bank of an eight-channel audio dac
// Assumes: core_clk_i is the master clock; serial pins are async
// Notes:   word is shifted while latch is low, taken on latch rise
`timescale 1ns/100ps
`default_nettype none

module dcr_bank
	import dcr_pkg::*;
(
	// clock and reset
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_n_i,
	// serial control pins
	input  wire logic                       link_clk_i,
	input  wire logic                       link_data_i,
	input  wire logic                       link_latch_i,
	// master clock monitor
	input  wire logic                       mclk_lost_i,
	// channel attenuation
	output logic [N_CH-1:0][ATT_W-1:0]      chan_atten_o,
	output logic [N_CH-1:0]                 chan_mute_o,
	// configuration
	output dcr_ctrl_t                       ctrl_o,
	output logic                            mute_pin_decode_disable_o,
	output logic [2:0]                      deemphasis_select_o,
	output logic [2:0]                      channel_soft_mute_o,
	output logic [1:0]                      zero_flag_select_o,
	// soft reset
	output logic                            soft_reset_o
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// channel slot of an attenuation address, or invalid
	function automatic logic [3:0] chan_slot(
		input logic [ADDR_W-1:0] addr
	);
		logic [3:0] r;
		r = 4'h8;
		case (addr)
			ADDR_LEFT1:  r = 4'h0;
			ADDR_RIGHT1: r = 4'h1;
			ADDR_LEFT2:  r = 4'h2;
			ADDR_RIGHT2: r = 4'h3;
			ADDR_LEFT3:  r = 4'h4;
			ADDR_RIGHT3: r = 4'h5;
			ADDR_LEFT4:  r = 4'h6;
			ADDR_RIGHT4: r = 4'h7;
			default:     r = 4'h8;
		endcase
		return r;
	endfunction

	// latch pin idles high; matching it avoids a false edge after reset
	localparam dcr_state_t STATE_RST = '{
		ctrl:     CTRL_RST,
		pending:  {N_CH{ATT_0DB}},
		active:   {N_CH{ATT_0DB}},
		lat_sync: 2'h3,
		lat_prev: 1'b1,
		default:  '0
	};

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	dcr_state_t                 s;
	dcr_state_t                 next_s;
	logic                       clk_rise;
	logic                       lat_rise;
	logic                       commit;
	logic [ADDR_W-1:0]          waddr;
	logic [DATA_W-1:0]          wdata;
	logic [3:0]                 slot;

	// ------------------------------------------------------------
	// edge detection on synchronised pins
	// ------------------------------------------------------------
	assign clk_rise = s.clk_sync[1] & ~s.clk_prev;
	assign lat_rise = s.lat_sync[1] & ~s.lat_prev;
	// short words are dropped; long words keep the last 16 bits
	assign commit   = lat_rise & (s.nbits >= WORD_BITS);
	assign waddr = s.shift[ADDR_MSB:ADDR_LSB];
	assign wdata = s.shift[DATA_MSB:0];
	assign slot  = chan_slot(waddr);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_s = s;
		// pins pass two flops before any logic sees them
		next_s.clk_sync  = {s.clk_sync[0], link_clk_i};
		next_s.dat_sync  = {s.dat_sync[0], link_data_i};
		next_s.lat_sync  = {s.lat_sync[0], link_latch_i};
		next_s.lost_sync = {s.lost_sync[0], mclk_lost_i};
		next_s.clk_prev  = s.clk_sync[1];
		next_s.lat_prev  = s.lat_sync[1];

		// shift msb first while latch low
		if (!s.lat_sync[1] && clk_rise) begin
			next_s.shift = {s.shift[WORD_W-2:0], s.dat_sync[1]};
			if (s.nbits < WORD_BITS) begin
				next_s.nbits = s.nbits + 5'h01;
			end
		end
		if (lat_rise) begin
			next_s.nbits = '0;
		end

		if (s.srst) begin
			if (s.srst_cnt <= SRST_CNT_W'(1)) begin
				next_s.srst     = 1'b0;
				next_s.srst_cnt = '0;
			end else begin
				next_s.srst_cnt = s.srst_cnt - SRST_CNT_W'(1);
			end
		end

		if (commit) begin
			// any new write ends soft reset; a write to the soft reset address restarts it
			next_s.srst     = 1'b0;
			next_s.srst_cnt = '0;
			if (slot < 4'h8) begin
				// value in 7:0, update in 8
				next_s.pending[slot[2:0]] = wdata[ATT_W-1:0];
				if (wdata[UPDATE_BIT]) begin
					next_s.active = next_s.pending;
				end
			end else begin
				case (waddr)
					ADDR_MASTER: begin
						// master value loads all channels
						next_s.ctrl.master_attenuation =
							{1'b0, wdata[ATT_W-1:0]};
						next_s.pending = {N_CH{wdata[ATT_W-1:0]}};
						if (wdata[UPDATE_BIT]) begin
							next_s.active = next_s.pending;
						end
					end
					ADDR_MZD: begin
						next_s.ctrl.mute_zero_detect_control = wdata;
					end
					ADDR_PFC: begin
						next_s.ctrl.phase_format_control = wdata;
					end
					ADDR_DMZ: begin
						next_s.ctrl.deemph_mute_zero_control = wdata;
					end
					ADDR_RMP: begin
						next_s.ctrl.rate_mode_powerdown = wdata;
					end
					ADDR_MPDL: begin
						next_s.ctrl.mute_pin_decode_legacy = wdata;
					end
					ADDR_CH4: begin
						next_s.ctrl.channel4_control = wdata;
					end
					ADDR_SRST: begin
						next_s.ctrl    = CTRL_RST;
						next_s.pending = {N_CH{ATT_0DB}};
						next_s.active  = {N_CH{ATT_0DB}};
						next_s.srst     = 1'b1;
						next_s.srst_cnt = SRST_CNT_W'(SRST_CYCLES);
					end
					default: begin
						next_s.ctrl = s.ctrl;
					end
				endcase
			end
		end

		// volumes back to 0 dB on clock loss
		// wins over a write landing the same cycle
		if (s.lost_sync[1]) begin
			next_s.pending = {N_CH{ATT_0DB}};
			next_s.active  = {N_CH{ATT_0DB}};
			next_s.ctrl.master_attenuation = RST_ATT;
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= STATE_RST;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign chan_atten_o = s.active;
	assign ctrl_o       = s.ctrl;
	assign soft_reset_o = s.srst;

	genvar gi;
	generate
		for (gi = 0; gi < N_CH; gi++) begin : g_mute
			assign chan_mute_o[gi] = (s.active[gi] == ATT_MUTE);
		end
	endgenerate

	// either copy of the decode-disable bit disables decode
	assign mute_pin_decode_disable_o =
		s.ctrl.mute_pin_decode_legacy[DECODE_OFF_LEGACY_BIT] |
		s.ctrl.channel4_control[DECODE_OFF_CH4_BIT];
	assign deemphasis_select_o =
		s.ctrl.deemph_mute_zero_control[8:6];
	assign channel_soft_mute_o =
		s.ctrl.deemph_mute_zero_control[5:3];
	assign zero_flag_select_o =
		s.ctrl.deemph_mute_zero_control[2:1];

endmodule

`default_nettype wire

//--- dcr_bank_monitor.sv
// Purpose: port assertions for the dac control register bank
// Assumes: single core clock domain, async active-low reset
// Notes:   bound onto every dcr_bank instance
`timescale 1ns/100ps
`default_nettype none
module dcr_bank_monitor
	import dcr_pkg::*;
(
	input wire logic                  core_clk_i,
	input wire logic                  rst_n_i,
	input wire logic                  link_clk_i,
	input wire logic                  link_data_i,
	input wire logic                  link_latch_i,
	input wire logic                  mclk_lost_i,
	input wire logic [N_CH-1:0][ATT_W-1:0] chan_atten_o,
	input wire logic [N_CH-1:0]       chan_mute_o,
	input wire dcr_ctrl_t             ctrl_o,
	input wire logic                  mute_pin_decode_disable_o,
	input wire logic [2:0]            deemphasis_select_o,
	input wire logic [2:0]            channel_soft_mute_o,
	input wire logic [1:0]            zero_flag_select_o,
	input wire logic                  soft_reset_o
);
	// ----
	// checks
	// ----
	logic [N_CH-1:0] mute_exp;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	always_comb begin
		for (int i = 0; i < N_CH; i++) begin
			mute_exp[i] = (chan_atten_o[i] == ATT_MUTE);
		end
	end
	mute_decode_a: assert property (chan_mute_o == mute_exp)
		else $error("channel mute does not follow zero code");
	pin_decode_a: assert property (mute_pin_decode_disable_o ==
		(ctrl_o.mute_pin_decode_legacy[DECODE_OFF_LEGACY_BIT]
		| ctrl_o.channel4_control[DECODE_OFF_CH4_BIT]))
		else $error("mute pin decode is not the or of both bits");
	field_map_a: assert property ({deemphasis_select_o,
		channel_soft_mute_o, zero_flag_select_o}
		== ctrl_o.deemph_mute_zero_control[8:1])
		else $error("decoded fields differ from register");
	srst_len_a: assert property ($rose(soft_reset_o) |=>
		soft_reset_o ##1 !soft_reset_o)
		else $error("soft reset pulse not two cycles");
	srst_dflt_a: assert property (soft_reset_o |->
		ctrl_o == CTRL_RST && &chan_atten_o)
		else $error("soft reset left a register off default");
	clk_loss_a: assert property (mclk_lost_i [*4] |->
		&chan_atten_o && ctrl_o.master_attenuation == RST_ATT)
		else $error("volumes not at 0 dB after clock loss");
	fmt_quiet_a: assert property ($changed(ctrl_o.phase_format_control)
		|-> $past(link_latch_i, 2) && !$past(link_latch_i, 6))
		else $error("format register changed without a word");
	upd_unlatched_a: assert property (
		ctrl_o.master_attenuation[UPDATE_BIT] == 1'b0)
		else $error("update bit was stored");
	cover property ($rose(soft_reset_o));
	cover property (|chan_mute_o);
	cover property (mclk_lost_i [*4]);
endmodule
bind dcr_bank dcr_bank_monitor dcr_bank_monitor_inst (
	.core_clk_i, .rst_n_i, .link_clk_i, .link_data_i, .link_latch_i,
	.mclk_lost_i, .chan_atten_o, .chan_mute_o, .ctrl_o,
	.mute_pin_decode_disable_o, .deemphasis_select_o,
	.channel_soft_mute_o, .zero_flag_select_o, .soft_reset_o
);
`default_nettype wire

//--- dcr_host.sv
// Purpose: host model on the three-wire control port
// Assumes: 80 ns link period, pins change 1 ns after core edge
// Notes:   link clock idles low; data idles inverted
`timescale 1ns/100ps
`default_nettype none
module dcr_host (
	input  wire logic clk_i,
	output logic      link_clk_o,
	output logic      link_data_o,
	output logic      link_latch_o
);
	initial begin
		link_clk_o = 1'b0;
		link_data_o = 1'b0;
		link_latch_o = 1'b1;
	end
	task automatic half();
		repeat (5) @(posedge clk_i);
		#1;
	endtask
	task automatic send(input logic [16:0] w, input int n);
		link_latch_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			link_data_o = w[i];
			half();
			link_clk_o = 1'b1;
			half();
			link_clk_o = 1'b0;
		end
		half();
		link_latch_o = 1'b1;
		// released data no longer holds its value
		link_data_o = ~link_data_o;
		half();
	endtask
endmodule
`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench for the control register bank
// Assumes: host model drives the serial pins
// Notes:   expected state queued per word, checked after latch
`timescale 1ns/100ps
`default_nettype none
module tb;
	import dcr_pkg::*;
	typedef struct packed {
		logic [N_CH-1:0][ATT_W-1:0] att;
		dcr_ctrl_t                  ctrl;
		logic [1:0]                 nsr;
	} dcr_exp_t;
	logic                       clk, rst_n, lclk, ldat, llat, lost;
	logic [N_CH-1:0][ATT_W-1:0] att, pend, act;
	logic [N_CH-1:0]            mute;
	dcr_ctrl_t                  ctrl, cfg;
	logic                       pin_dec, srst;
	logic [2:0]                 dem, smu;
	logic [1:0]                 zfs;
	logic [ADDR_W-1:0]          cha [N_CH] = '{ADDR_LEFT1, ADDR_RIGHT1,
		ADDR_LEFT2, ADDR_RIGHT2, ADDR_LEFT3, ADDR_RIGHT3, ADDR_LEFT4,
		ADDR_RIGHT4};
	logic [ADDR_W-1:0]          bad [5] = '{7'h0b, 7'h10, 7'h1e, 7'h20, 7'h7f};
	dcr_exp_t                   q [$];
	int                         n_fail, num_checks, cyc;
	dcr_bank dcr_bank_inst (
		.core_clk_i(clk), .rst_n_i(rst_n), .link_clk_i(lclk),
		.link_data_i(ldat), .link_latch_i(llat), .mclk_lost_i(lost),
		.chan_atten_o(att), .chan_mute_o(mute), .ctrl_o(ctrl),
		.mute_pin_decode_disable_o(pin_dec), .deemphasis_select_o(dem),
		.channel_soft_mute_o(smu), .zero_flag_select_o(zfs),
		.soft_reset_o(srst)
	);
	dcr_host dcr_host_inst (
		.clk_i(clk), .link_clk_o(lclk), .link_data_o(ldat), .link_latch_o(llat)
	);
	// ----
	// tasks
	// ----
	task automatic chk(input string nm, input logic [127:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// short words drop, long words keep the last sixteen bits
	task automatic wr(input logic [6:0] a, input logic [8:0] d, input int n);
		int ch;
		ch = -1;
		for (int i = 0; i < N_CH; i++) begin
			if (cha[i] == a) begin
				ch = i;
			end
		end
		if (n >= 16) begin
			if (a == ADDR_SRST) begin
				pend = '1;
				act = '1;
				cfg = CTRL_RST;
			end else if (a == ADDR_MASTER) begin
				pend = {N_CH{d[7:0]}};
				cfg.master_attenuation = {1'b0, d[7:0]};
			end else if (ch >= 0) begin
				pend[ch] = d[7:0];
			end else begin
				case (a)
					ADDR_MZD: cfg.mute_zero_detect_control = d;
					ADDR_PFC: cfg.phase_format_control = d;
					ADDR_DMZ: cfg.deemph_mute_zero_control = d;
					ADDR_RMP: cfg.rate_mode_powerdown = d;
					ADDR_MPDL: cfg.mute_pin_decode_legacy = d;
					ADDR_CH4: cfg.channel4_control = d;
					default: ;
				endcase
			end
			if (d[8] && (ch >= 0 || a == ADDR_MASTER)) begin
				act = pend;
			end
		end
		q.push_back('{act, cfg, (n >= 16 && a == ADDR_SRST) ? 2'h2 : 2'h0});
		dcr_host_inst.send({1'b1, a, d}, n);
	endtask
	// ----
	// clock, watchdog, result watcher, main sequence
	// ----
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			n_fail++;
			print_verdict();
		end
	end
	initial begin
		dcr_exp_t        e;
		logic [N_CH-1:0] m;
		logic [7:0]      f;
		logic            md;
		int              k;
		// latch pin rises from unknown at time zero; skip that edge
		wait (rst_n === 1'b1);
		forever begin
			@(posedge llat);
			k = 0;
			repeat (7) begin
				@(posedge clk);
				#2;
				k += 32'(srst);
			end
			if (q.size() > 0) begin
				e = q.pop_front();
				for (int i = 0; i < N_CH; i++) begin
					m[i] = (e.att[i] == 8'h00);
				end
				chk("atten", 128'(att), 128'(e.att));
				chk("config", 128'(ctrl), 128'(e.ctrl));
				chk("mute", 128'(mute), 128'(m));
				chk("soft_reset_len", 128'(k), 128'(e.nsr));
				md = e.ctrl.mute_pin_decode_legacy[DECODE_OFF_LEGACY_BIT]
					| e.ctrl.channel4_control[DECODE_OFF_CH4_BIT];
				f = e.ctrl.deemph_mute_zero_control[8:1];
				chk("pin_decode", 128'(pin_dec), 128'(md));
				chk("fields", 128'({dem, smu, zfs}), 128'(f));
			end
		end
	end
	initial begin
		rst_n = 1'b0;
		lost = 1'b0;
		pend = '1;
		act = '1;
		cfg = CTRL_RST;
		void'($urandom(75900));
		repeat (5) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk("atten_reset", 128'(att), 128'(act));
		chk("config_reset", 128'(ctrl), 128'(cfg));
		foreach (bad[i]) begin
			wr(bad[i], 9'($urandom), 16);
		end
		wr(ADDR_MZD, 9'($urandom), 16);
		wr(ADDR_PFC, 9'($urandom), 16);
		wr(ADDR_DMZ, 9'($urandom), 16);
		wr(ADDR_RMP, 9'($urandom) & 9'h1fe, 16);
		wr(ADDR_MPDL, 9'($urandom) & 9'h040, 16);
		wr(ADDR_CH4, 9'($urandom) & 9'h03f, 16);
		foreach (cha[i]) begin
			wr(cha[i], {1'b0, 8'($urandom)}, 16);
		end
		wr(ADDR_LEFT1, 9'h000, 16);
		wr(ADDR_RIGHT4, {1'b1, 8'($urandom)}, 16);
		wr(ADDR_MASTER, 9'h001, 16);
		wr(ADDR_LEFT2, 9'h1fe, 16);
		wr(ADDR_MASTER, 9'h100, 16);
		wr(ADDR_PFC, 9'($urandom), 15);
		wr(ADDR_PFC, 9'($urandom), 17);
		wr(ADDR_SRST, 9'h000, 16);
		wr(ADDR_RIGHT3, 9'h1aa, 16);
		lost = 1'b1;
		pend = '1;
		act = '1;
		cfg.master_attenuation = RST_ATT;
		repeat (6) @(posedge clk);
		#1;
		chk("atten_lost", 128'(att), 128'(act));
		chk("config_lost", 128'(ctrl), 128'(cfg));
		lost = 1'b0;
		wr(ADDR_LEFT1, 9'h180, 16);
		repeat (10) @(posedge clk);
		print_verdict();
	end
endmodule
`default_nettype wire
